/* logic/sid_map.svh */
// constants for the status indicator driver
// assumes a 50 MHz ref_clk
`ifndef SID_MAP_SVH
`define SID_MAP_SVH
`define SID_CLK_HZ 50000000
`define SID_BLINK_HALF_MS 250
`define SID_BLINK_HALF_CYC ((`SID_CLK_HZ / 1000) * `SID_BLINK_HALF_MS)
`define SID_ACT_HOLD_MS 50
`define SID_ACT_HOLD_CYC ((`SID_CLK_HZ / 1000) * `SID_ACT_HOLD_MS)
`define SID_CNT_W 24
`endif

/* logic/sid_pkg.sv */
// types for the status indicator driver
// assumes sid_map.svh holds the numbers
`default_nettype none
package sid_pkg;
  typedef enum logic [2:0] {
    SID_OFF,
    SID_GREEN,
    SID_GREEN_FLASH,
    SID_RED,
    SID_RED_FLASH,
    SID_ALTERNATE
  } sid_duo_t;
endpackage : sid_pkg
`default_nettype wire

/* logic/sid_top.sv */
// status indicator driver: two duo lamps, link lamp, traffic lamp
// assumes status flags from firmware on ref_clk; phy flags from pins
`include "sid_map.svh"
`default_nettype none
module sid_top
  import sid_pkg::*;
#(
  parameter int unsigned BLINK_HALF = `SID_BLINK_HALF_CYC,
  parameter int unsigned ACT_HOLD = `SID_ACT_HOLD_CYC
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // firmware status
  input wire logic self_test,
  input wire logic operational,
  input wire logic configured,
  input wire logic major_fault,
  input wire logic minor_fault,
  input wire logic config_bad,
  input wire logic have_ip,
  input wire logic conn_any,
  input wire logic dup_ip,
  input wire logic conn_timeout,
  input wire logic conn_all_ok,
  // phy pins
  input wire logic phy_link,
  input wire logic phy_frame,
  // lamp drives
  output logic module_health_lamp_green,
  output logic module_health_lamp_red,
  output logic network_health_lamp_green,
  output logic network_health_lamp_red,
  output logic link_up_lamp,
  output logic traffic_lamp
);
  logic [`SID_CNT_W-1:0] blink_cnt;
  logic blink;
  logic [1:0] link_sync;
  logic [1:0] frame_sync;
  logic frame_prev;
  logic [`SID_CNT_W-1:0] act_cnt;
  logic timeout_latched;
  sid_duo_t ms_state;
  sid_duo_t ns_state;
  sid_duo_t next_ms;
  sid_duo_t next_ns;

  // shared blink generator
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else if (blink_cnt >= `SID_CNT_W'(BLINK_HALF - 1))
    begin
      blink_cnt <= '0;
      blink <= ~blink;
    end
    else
    begin
      blink_cnt <= blink_cnt + `SID_CNT_W'(1);
    end
  end

  // pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      link_sync <= 2'b00;
      frame_sync <= 2'b00;
      frame_prev <= 1'b0;
    end
    else
    begin
      link_sync <= {link_sync[0], phy_link};
      frame_sync <= {frame_sync[0], phy_frame};
      frame_prev <= frame_sync[1];
    end
  end

  // timeout latch, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      timeout_latched <= 1'b0;
    else if (conn_timeout)
      timeout_latched <= 1'b1;
    else if (conn_all_ok)
      timeout_latched <= 1'b0;
  end

  // module lamp selection
  always_comb
  begin
    if (self_test)
      next_ms = SID_ALTERNATE;
    else if (major_fault)
      next_ms = SID_RED;
    else if (minor_fault || config_bad)
      next_ms = SID_RED_FLASH;
    else if (!configured)
      next_ms = SID_GREEN_FLASH;
    else if (operational)
      next_ms = SID_GREEN;
    else
      next_ms = SID_OFF;
  end

  // network lamp selection
  always_comb
  begin
    if (self_test)
      next_ns = SID_ALTERNATE;
    else if (!have_ip)
      next_ns = SID_OFF;
    else if (dup_ip)
      next_ns = SID_RED;
    else if (timeout_latched)
      next_ns = SID_RED_FLASH;
    else if (conn_any)
      next_ns = SID_GREEN;
    else
      next_ns = SID_GREEN_FLASH;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ms_state <= SID_OFF;
      ns_state <= SID_OFF;
    end
    else
    begin
      ms_state <= next_ms;
      ns_state <= next_ns;
    end
  end

  // drive a duo lamp from its state
  function automatic logic [1:0] duo_drive(input sid_duo_t st, input logic bl);
    case (st)
      SID_GREEN: duo_drive = 2'b10;
      SID_GREEN_FLASH: duo_drive = {bl, 1'b0};
      SID_RED: duo_drive = 2'b01;
      SID_RED_FLASH: duo_drive = {1'b0, bl};
      SID_ALTERNATE: duo_drive = {bl, ~bl};
      default: duo_drive = 2'b00;
    endcase
  endfunction : duo_drive

  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      {module_health_lamp_green, module_health_lamp_red} <= 2'b00;
      {network_health_lamp_green, network_health_lamp_red} <= 2'b00;
    end
    else
    begin
      {module_health_lamp_green, module_health_lamp_red} <= duo_drive(ms_state, blink);
      {network_health_lamp_green, network_health_lamp_red} <= duo_drive(ns_state, blink);
    end
  end

  // link lamp
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      link_up_lamp <= 1'b0;
    else
      link_up_lamp <= link_sync[1];
  end

  // traffic lamp: a frame edge while act_cnt is zero starts a blink window; edges during a window are ignored
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      act_cnt <= '0;
      traffic_lamp <= 1'b0;
    end
    else
    begin
      if (frame_sync[1] && !frame_prev && act_cnt == '0)
        act_cnt <= `SID_CNT_W'(ACT_HOLD * 2 - 1);
      else if (act_cnt != '0)
        act_cnt <= act_cnt - `SID_CNT_W'(1);
      traffic_lamp <= (act_cnt >= `SID_CNT_W'(ACT_HOLD));
    end
  end

  // checks
  property p_major_red;
    @(posedge ref_clk) disable iff (!resetn)
      (major_fault && !self_test) ##1 (major_fault && !self_test)
      |=> module_health_lamp_red && !module_health_lamp_green;
  endproperty
  a_major_red: assert property (p_major_red) else $error("major fault not steady red");

  property p_ms_green;
    @(posedge ref_clk) disable iff (!resetn)
      (operational && configured && !self_test && !major_fault && !minor_fault
        && !config_bad)[*2] |=> module_health_lamp_green && !module_health_lamp_red;
  endproperty
  a_ms_green: assert property (p_ms_green) else $error("operational not green");

  property p_ms_standby;
    @(posedge ref_clk) disable iff (!resetn)
      (!configured && !self_test && !major_fault && !minor_fault && !config_bad)[*2]
      |=> !module_health_lamp_red && module_health_lamp_green == $past(blink);
  endproperty
  a_ms_standby: assert property (p_ms_standby) else $error("standby not green flash");

  property p_ms_minor;
    @(posedge ref_clk) disable iff (!resetn)
      ((minor_fault || config_bad) && !major_fault && !self_test)[*2]
      |=> !module_health_lamp_green && module_health_lamp_red == $past(blink);
  endproperty
  a_ms_minor: assert property (p_ms_minor) else $error("minor fault not red flash");

  property p_selftest_ms;
    @(posedge ref_clk) disable iff (!resetn)
      self_test[*2] |=> module_health_lamp_green != module_health_lamp_red;
  endproperty
  a_selftest_ms: assert property (p_selftest_ms) else $error("self-test not alternating");

  property p_selftest_ns;
    @(posedge ref_clk) disable iff (!resetn)
      self_test[*2] |=> network_health_lamp_green != network_health_lamp_red;
  endproperty
  a_selftest_ns: assert property (p_selftest_ns) else $error("net self-test wrong");

  property p_no_ip_off;
    @(posedge ref_clk) disable iff (!resetn)
      (!have_ip && !self_test)[*2] |=> !network_health_lamp_green && !network_health_lamp_red;
  endproperty
  a_no_ip_off: assert property (p_no_ip_off) else $error("net lamp lit without ip");

  property p_ns_conn;
    @(posedge ref_clk) disable iff (!resetn)
      (have_ip && conn_any && !dup_ip && !timeout_latched && !self_test)[*2]
      |=> network_health_lamp_green && !network_health_lamp_red;
  endproperty
  a_ns_conn: assert property (p_ns_conn) else $error("connected not green");

  property p_ns_idle;
    @(posedge ref_clk) disable iff (!resetn)
      (have_ip && !conn_any && !dup_ip && !timeout_latched && !self_test)[*2]
      |=> !network_health_lamp_red && network_health_lamp_green == $past(blink);
  endproperty
  a_ns_idle: assert property (p_ns_idle) else $error("no connection not green flash");

  property p_ns_timeout;
    @(posedge ref_clk) disable iff (!resetn)
      (timeout_latched && have_ip && !dup_ip && !self_test)[*2]
      |=> !network_health_lamp_green && network_health_lamp_red == $past(blink);
  endproperty
  a_ns_timeout: assert property (p_ns_timeout) else $error("timeout not red flash");

  property p_timeout_latch;
    @(posedge ref_clk) disable iff (!resetn)
      conn_timeout |=> timeout_latched;
  endproperty
  a_timeout_latch: assert property (p_timeout_latch) else $error("timeout not latched");

  property p_timeout_hold;
    @(posedge ref_clk) disable iff (!resetn)
      timeout_latched && !conn_all_ok |=> timeout_latched;
  endproperty
  a_timeout_hold: assert property (p_timeout_hold) else $error("timeout dropped early");

  property p_link;
    @(posedge ref_clk) disable iff (!resetn)
      phy_link[*3] |=> link_up_lamp;
  endproperty
  a_link: assert property (p_link) else $error("link lamp dark with link up");

  property p_link_off;
    @(posedge ref_clk) disable iff (!resetn)
      (!phy_link)[*3] |=> !link_up_lamp;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link lamp lit with link down");

  property p_dup_red;
    @(posedge ref_clk) disable iff (!resetn)
      (dup_ip && have_ip && !self_test)[*2]
      |=> network_health_lamp_red && !network_health_lamp_green;
  endproperty
  a_dup_red: assert property (p_dup_red) else $error("duplicate ip not red");

  c_selftest: cover property (@(posedge ref_clk) self_test ##1 !self_test);
  c_timeout: cover property (@(posedge ref_clk) conn_timeout ##[1:5] conn_all_ok);
  c_traffic: cover property (@(posedge ref_clk) $rose(traffic_lamp));
endmodule : sid_top
`default_nettype wire

/* test/sid_top_tb.sv */
// self-checking bench for sid_top: random and directed status flags
// assumes short blink and hold counts set at the instance
`default_nettype none
module sid_top_tb
  import sid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BH = 4;
  localparam int AH = 3;
  logic ref_clk = 0, resetn = 0, self_test = 0, operational = 0, configured = 0;
  logic major_fault = 0, minor_fault = 0, config_bad = 0, have_ip = 0, conn_any = 0;
  logic dup_ip = 0, conn_timeout = 0, conn_all_ok = 0, phy_link = 0, phy_frame = 0;
  logic module_health_lamp_green, module_health_lamp_red, network_health_lamp_green;
  logic network_health_lamp_red, link_up_lamp, traffic_lamp, latch = 0;
  int n_errors = 0, checks_done = 0, seed = 77;
  sid_top #(.BLINK_HALF(BH), .ACT_HOLD(AH)) DUT (.ref_clk, .resetn, .self_test,
    .operational, .configured, .major_fault, .minor_fault, .config_bad, .have_ip,
    .conn_any, .dup_ip, .conn_timeout, .conn_all_ok, .phy_link, .phy_frame,
    .module_health_lamp_green, .module_health_lamp_red, .network_health_lamp_green,
    .network_health_lamp_red, .link_up_lamp, .traffic_lamp);
  always #10 ref_clk = ~ref_clk;
  function automatic sid_duo_t exp_mod(input logic st, mj, mn, cb, cf, op);
    if (st) return SID_ALTERNATE;
    if (mj) return SID_RED;
    if (mn | cb) return SID_RED_FLASH;
    if (!cf) return SID_GREEN_FLASH;
    return op ? SID_GREEN : SID_OFF;
  endfunction : exp_mod
  function automatic sid_duo_t exp_net(input logic st, ip, dp, lt, ca);
    if (st) return SID_ALTERNATE;
    if (!ip) return SID_OFF;
    if (dp) return SID_RED;
    if (lt) return SID_RED_FLASH;
    return ca ? SID_GREEN : SID_GREEN_FLASH;
  endfunction : exp_net
  // steady, flashing or alternating from lit counts over a window
  function automatic sid_duo_t classify(input int g, r, n);
    if (g == 0 && r == 0) return SID_OFF;
    if (r == 0) return (g == n) ? SID_GREEN : SID_GREEN_FLASH;
    if (g == 0) return (r == n) ? SID_RED : SID_RED_FLASH;
    return SID_ALTERNATE;
  endfunction : classify
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic run_case(input logic [11:0] f);
    int mg = 0, mr = 0, ng = 0, nr = 0, tr = 0;
    sid_duo_t em, en;
    @(negedge ref_clk);
    {self_test, operational, configured, major_fault, minor_fault, config_bad,
      have_ip, conn_any, dup_ip, conn_timeout, conn_all_ok, phy_link} = f;
    if (conn_timeout) latch = 1;
    else if (conn_all_ok) latch = 0;
    repeat (4) @(posedge ref_clk);
    repeat (4 * BH)
    begin
      @(posedge ref_clk);
      #1;
      mg += (module_health_lamp_green !== 1'b0);
      mr += (module_health_lamp_red !== 1'b0);
      ng += (network_health_lamp_green !== 1'b0);
      nr += (network_health_lamp_red !== 1'b0);
      tr += (traffic_lamp !== 1'b0);
    end
    em = exp_mod(self_test, major_fault, minor_fault, config_bad, configured, operational);
    en = exp_net(self_test, have_ip, dup_ip, latch, conn_any);
    compare(8'(classify(mg, mr, 4 * BH)), 8'(em));
    compare(8'(classify(ng, nr, 4 * BH)), 8'(en));
    compare(8'(link_up_lamp), 8'(phy_link));
    compare(8'(tr), 8'h00);
    $display("case %h done", f);
  endtask : run_case
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : results
  initial
  begin
    #(20 * 20000);
    n_errors++;
    results();
  end
  initial
  begin
    logic [31:0] r;
    int tr;
    repeat (4) @(negedge ref_clk);
    resetn = 1;
    run_case(12'b0110_0011_0001);
    run_case(12'b0000_0010_0000);
    run_case(12'b1111_1111_1111);
    run_case(12'b0111_1011_1000);
    run_case(12'b0110_0100_0000);
    run_case(12'b0110_1011_0101);
    run_case(12'b0110_0011_0000);
    run_case(12'b0110_0011_0010);
    run_case(12'b0110_0011_0100);
    @(negedge ref_clk);
    resetn = 0;
    conn_timeout = 0;
    latch = 0;
    repeat (4) @(negedge ref_clk);
    resetn = 1;
    run_case(12'b0110_0011_0000);
    @(negedge ref_clk);
    phy_frame = 1;
    @(negedge ref_clk);
    phy_frame = 0;
    tr = 0;
    repeat (14)
    begin
      @(posedge ref_clk);
      #1;
      tr += (traffic_lamp === 1'b1);
    end
    compare(8'(tr), 8'(AH));
    $display("traffic case done");
    repeat (40)
    begin
      r = $random(seed);
      run_case({r[2:0] == 0, r[14] | r[15], r[12] | r[13], r[5:3] == 0, r[8:6] == 0,
        r[11:9] == 0, r[16] | r[17], r[18], r[21:19] == 0, r[24:22] == 0, r[25],
        r[26]});
    end
    results();
  end
endmodule : sid_top_tb
`default_nettype wire
